// ===== design/alhb_alarm_ladder.sv
// Purpose: Alert flags, alarm masking and the alarm ladder heartbeat for one chained monitor.
// Assumes: All inputs synchronous to aclk; measurement results arrive already digitised.
// Notes: Registers are reached over AXI4-Lite; each output comes from a flip-flop.
//
// Chosen here: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "alhb_params.svh"

module alhb_alarm_ladder #(
    parameter int CELLS = 12
) (
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite slave.
    input wire alhb_pkg::alhb_addr_t s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire alhb_pkg::alhb_data_t s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire alhb_pkg::alhb_addr_t s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output alhb_pkg::alhb_data_t s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Measurement results.
    input wire logic [CELLS-1:0] per_cell_over_bits,
    input wire logic [CELLS-1:0] per_cell_under_bits,
    input wire alhb_pkg::alhb_word_t highest_cell_reading,
    input wire alhb_pkg::alhb_word_t lowest_cell_reading,
    input wire alhb_pkg::alhb_word_t aux_input_zero,
    input wire alhb_pkg::alhb_word_t aux_input_one,
    input wire logic aux_sample_done,
    // Communication error events, one-cycle pulses.
    input wire logic crc_error_event,
    input wire logic nack_error_event,
    // Operational failure events: pump, reference, low supply, low ground.
    input wire logic pump_fail_event,
    input wire logic reference_fail_event,
    input wire logic low_supply_fail_event,
    input wire logic low_ground_fail_event,
    // Alarm ladder.
    input wire logic alarm_upper_port,
    output logic alarm_lower_port
);
    import alhb_pkg::*;

    // ------------------------------------------------------------------
    // State record.
    // ------------------------------------------------------------------
    typedef struct packed {
        logic awready;
        logic wready;
        logic aw_got;
        logic w_got;
        alhb_addr_t awaddr;
        alhb_data_t wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [1:0] rresp;
        alhb_data_t rdata;
        logic [`ALHB_ST_WIDTH-1:0] status;
        logic [`ALHB_FL_WIDTH-1:0] failure;
        logic [6:0] enables;
        alhb_word_t address;
        alhb_word_t spread_thr;
        alhb_word_t cold_thr;
        alhb_word_t hot_thr;
        logic [15:0] hb_gen_cnt;
        logic hb_gen;
        logic [15:0] hb_mon_cnt;
        logic upper_prev;
        logic lower;
    } alhb_state_s;

    alhb_state_s st_q; // Registered state.
    alhb_state_s st_d; // Next state.

    // Decoded half period and monitor window, cut to the counter width.
    localparam logic [15:0] HB_HALF = 16'(`ALHB_HB_HALF_CYC);
    localparam logic [15:0] HB_MIN = 16'(`ALHB_HB_MIN_CYC);
    localparam logic [15:0] HB_MAX = 16'(`ALHB_HB_MAX_CYC);

    // Combinational helpers.
    logic [31:0] wmask; // Byte-enable expanded mask.
    logic [31:0] zclr; // Bits written to zero under their byte enable.
    logic do_write; // Both write halves are held and no response pending.
    logic [7:0] widx; // Register index of the write.
    logic [7:0] ridx; // Register index of the read.
    logic top_device; // This device starts the heartbeat.
    logic alarm; // Local alarm condition.
    logic upper_edge; // Upper port changed level.
    logic spread_hit; // Highest minus lowest above threshold.
    logic cold_hit0; // Aux zero above cold threshold.
    logic cold_hit1; // Aux one above cold threshold.
    logic hot_hit0; // Aux zero below hot threshold.
    logic hot_hit1; // Aux one below hot threshold.
    logic hb_fault; // Upper heartbeat out of window.
    logic [`ALHB_FL_WIDTH-1:0] fail_set; // Failure set events.
    alhb_word_t spread_diff; // Spread between extremes.

    // ------------------------------------------------------------------
    // Next-state logic.
    // ------------------------------------------------------------------
    // One process computes everything; set events are ORed last so that a
    // flag raised in the cycle of its clearing write survives.
    always_comb begin
        st_d = st_q;
        wmask = {{8{st_q.wstrb[3]}}, {8{st_q.wstrb[2]}}, {8{st_q.wstrb[1]}}, {8{st_q.wstrb[0]}}};
        zclr = wmask & ~st_q.wdata;
        do_write = st_q.aw_got && st_q.w_got && !st_q.bvalid;
        widx = {2'b00, st_q.awaddr[7:2]};
        ridx = {2'b00, s_axi_araddr[7:2]};

        // Threshold comparisons on the current readings.
        spread_diff = highest_cell_reading - lowest_cell_reading;
        spread_hit = (st_q.spread_thr != `ALHB_SPREAD_OFF) && (spread_diff > st_q.spread_thr);
        cold_hit0 = aux_input_zero > st_q.cold_thr;
        cold_hit1 = aux_input_one > st_q.cold_thr;
        hot_hit0 = aux_input_zero < st_q.hot_thr;
        hot_hit1 = aux_input_one < st_q.hot_thr;

        // Top when the last-address field matches the own-address field.
        top_device = st_q.address[12:8] == st_q.address[4:0];

        // Upper heartbeat monitor; the top device has nothing above it.
        upper_edge = alarm_upper_port != st_q.upper_prev;
        st_d.upper_prev = alarm_upper_port;
        hb_fault = 1'b0;
        if (top_device) begin
            st_d.hb_mon_cnt = 16'h0000;
        end else if (upper_edge) begin
            // An edge too soon after the previous one is out of spec.
            hb_fault = st_q.hb_mon_cnt < HB_MIN;
            st_d.hb_mon_cnt = 16'h0000;
        end else if (st_q.hb_mon_cnt == HB_MAX) begin
            // No edge for too long: stuck line; count restarts to re-flag.
            hb_fault = 1'b1;
            st_d.hb_mon_cnt = 16'h0000;
        end else begin
            st_d.hb_mon_cnt = st_q.hb_mon_cnt + 16'h0001;
        end

        // Failure word events: pump, heartbeat, reference, supply, ground.
        fail_set = {low_ground_fail_event, low_supply_fail_event, reference_fail_event, hb_fault, pump_fail_event};

        // ---------------- Write channel ----------------
        if (s_axi_awvalid && st_q.awready) begin
            st_d.aw_got = 1'b1;
            st_d.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && st_q.wready) begin
            st_d.w_got = 1'b1;
            st_d.wdata = s_axi_wdata;
            st_d.wstrb = s_axi_wstrb;
        end
        if (st_q.bvalid && s_axi_bready) begin
            st_d.bvalid = 1'b0;
        end
        if (do_write) begin
            st_d.aw_got = 1'b0;
            st_d.w_got = 1'b0;
            st_d.bvalid = 1'b1;
            st_d.bresp = `ALHB_RESP_OKAY;
            case (widx)
                `ALHB_IDX_STATUS: begin
                    // Only latched flags clear on a written zero; level flags ignore it.
                    st_d.status[`ALHB_ST_RESET] = st_q.status[`ALHB_ST_RESET] & ~zclr[`ALHB_ST_RESET];
                    st_d.status[`ALHB_ST_CRC] = st_q.status[`ALHB_ST_CRC] & ~zclr[`ALHB_ST_CRC];
                    st_d.status[`ALHB_ST_NACK] = st_q.status[`ALHB_ST_NACK] & ~zclr[`ALHB_ST_NACK];
                    st_d.status[`ALHB_ST_AUX1] = st_q.status[`ALHB_ST_AUX1] & ~zclr[`ALHB_ST_AUX1];
                    st_d.status[`ALHB_ST_AUX0] = st_q.status[`ALHB_ST_AUX0] & ~zclr[`ALHB_ST_AUX0];
                end
                `ALHB_IDX_FAILURE: begin
                    st_d.failure = st_q.failure & ~zclr[`ALHB_FL_WIDTH-1:0];
                end
                `ALHB_IDX_ADDRESS: begin
                    st_d.address = (st_q.address & ~wmask[15:0]) | (st_q.wdata[15:0] & wmask[15:0]);
                end
                `ALHB_IDX_CONFIG: begin
                    st_d.enables = (st_q.enables & ~wmask[6:0]) | (st_q.wdata[6:0] & wmask[6:0]);
                end
                `ALHB_IDX_SPREAD: begin
                    st_d.spread_thr = (st_q.spread_thr & ~wmask[15:0]) | (st_q.wdata[15:0] & wmask[15:0]);
                end
                `ALHB_IDX_COLD: begin
                    st_d.cold_thr = (st_q.cold_thr & ~wmask[15:0]) | (st_q.wdata[15:0] & wmask[15:0]);
                end
                `ALHB_IDX_HOT: begin
                    st_d.hot_thr = (st_q.hot_thr & ~wmask[15:0]) | (st_q.wdata[15:0] & wmask[15:0]);
                end
                default: begin
                    st_d.bresp = `ALHB_RESP_SLVERR;
                end
            endcase
        end
        // One write at a time: each half is refused until its previous one is done.
        st_d.awready = !st_d.aw_got && !st_d.bvalid;
        st_d.wready = !st_d.w_got && !st_d.bvalid;

        // ---------------- Read channel ----------------
        if (st_q.rvalid && s_axi_rready) begin
            st_d.rvalid = 1'b0;
        end
        if (s_axi_arvalid && st_q.arready) begin
            st_d.rvalid = 1'b1;
            st_d.rresp = `ALHB_RESP_OKAY;
            st_d.rdata = 32'h0000_0000;
            case (ridx)
                `ALHB_IDX_STATUS: st_d.rdata[`ALHB_ST_WIDTH-1:0] = st_q.status;
                `ALHB_IDX_FAILURE: st_d.rdata[`ALHB_FL_WIDTH-1:0] = st_q.failure;
                `ALHB_IDX_ADDRESS: st_d.rdata[15:0] = st_q.address;
                `ALHB_IDX_CONFIG: st_d.rdata[6:0] = st_q.enables;
                `ALHB_IDX_SPREAD: st_d.rdata[15:0] = st_q.spread_thr;
                `ALHB_IDX_COLD: st_d.rdata[15:0] = st_q.cold_thr;
                `ALHB_IDX_HOT: st_d.rdata[15:0] = st_q.hot_thr;
                default: st_d.rresp = `ALHB_RESP_SLVERR;
            endcase
        end
        st_d.arready = !st_d.rvalid;

        // ---------------- Alert flags ----------------
        // Level flags follow their condition and drop when it ends.
        st_d.status[`ALHB_ST_OVER] = |per_cell_over_bits;
        st_d.status[`ALHB_ST_UNDER] = |per_cell_under_bits;
        st_d.status[`ALHB_ST_SPREAD] = spread_hit;
        st_d.status[`ALHB_ST_COLD] = cold_hit0 || cold_hit1;
        st_d.status[`ALHB_ST_HOT] = hot_hit0 || hot_hit1;
        // Sticky events: set wins over a same-cycle clear.
        st_d.status[`ALHB_ST_CRC] = st_d.status[`ALHB_ST_CRC] | crc_error_event;
        st_d.status[`ALHB_ST_NACK] = st_d.status[`ALHB_ST_NACK] | nack_error_event;
        st_d.failure = st_d.failure | fail_set;
        st_d.status[`ALHB_ST_FAIL] = |st_d.failure;
        // Window flags are re-evaluated only when a new aux result lands,
        // so a cleared condition stays flagged until the next measurement.
        if (aux_sample_done) begin
            st_d.status[`ALHB_ST_AUX1] = cold_hit1 || hot_hit1;
            st_d.status[`ALHB_ST_AUX0] = cold_hit0 || hot_hit0;
        end

        // ---------------- Alarm and ladder ----------------
        // Reset flag has no mask; over, under, spread, cold, hot, CRC and NACK are gated by their enables; fail and aux flags never alarm.
        alarm = st_q.status[`ALHB_ST_RESET]
              | (st_q.status[`ALHB_ST_OVER] & st_q.enables[0])
              | (st_q.status[`ALHB_ST_UNDER] & st_q.enables[1])
              | (st_q.status[`ALHB_ST_SPREAD] & st_q.enables[2])
              | (st_q.status[`ALHB_ST_COLD] & st_q.enables[3])
              | (st_q.status[`ALHB_ST_HOT] & st_q.enables[4])
              | (st_q.status[`ALHB_ST_CRC] & st_q.enables[5])
              | (st_q.status[`ALHB_ST_NACK] & st_q.enables[6]);

        // Free-running divider; toggles every half period.
        if (st_q.hb_gen_cnt >= HB_HALF - 16'h0001) begin
            st_d.hb_gen_cnt = 16'h0000;
            st_d.hb_gen = !st_q.hb_gen;
        end else begin
            st_d.hb_gen_cnt = st_q.hb_gen_cnt + 16'h0001;
        end

        // Alarm overrides; else top sources, others pass through.
        if (alarm) begin
            st_d.lower = 1'b1;
        end else if (top_device) begin
            st_d.lower = st_q.hb_gen;
        end else begin
            st_d.lower = alarm_upper_port;
        end
    end

    // ------------------------------------------------------------------
    // State register.
    // ------------------------------------------------------------------
    // Synchronous reset; the reset flag comes up set so the device alarms
    // until software acknowledges the power-on event.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_q <= '0;
            st_q.status[`ALHB_ST_RESET] <= 1'b1;
            st_q.address <= `ALHB_ADDR_RST;
            st_q.spread_thr <= `ALHB_SPREAD_OFF;
            st_q.cold_thr <= `ALHB_COLD_RST;
            st_q.hot_thr <= `ALHB_HOT_RST;
            st_q.lower <= 1'b1;
        end else begin
            st_q <= st_d;
        end
    end

    // ------------------------------------------------------------------
    // Outputs, all straight from the state register.
    // ------------------------------------------------------------------
    assign s_axi_awready = st_q.awready;
    assign s_axi_wready = st_q.wready;
    assign s_axi_bvalid = st_q.bvalid;
    assign s_axi_bresp = st_q.bresp;
    assign s_axi_arready = st_q.arready;
    assign s_axi_rvalid = st_q.rvalid;
    assign s_axi_rresp = st_q.rresp;
    assign s_axi_rdata = st_q.rdata;
    assign alarm_lower_port = st_q.lower;

endmodule : alhb_alarm_ladder

// ===== design/alhb_params.svh
// Purpose: Constants for the alert, alarm and heartbeat ladder block.
// Assumes: 100 MHz system clock; register words on AXI4-Lite at four times their index.
// Notes: Field positions and reset values live here; types live in alhb_pkg.
`ifndef ALHB_PARAMS_SVH
`define ALHB_PARAMS_SVH

// ----------------------------------------------------------------------
// Register indices; byte address is four times the index.
// ----------------------------------------------------------------------
`define ALHB_IDX_STATUS 8'h00
`define ALHB_IDX_ADDRESS 8'h01
`define ALHB_IDX_CONFIG 8'h08
`define ALHB_IDX_FAILURE 8'h10
`define ALHB_IDX_SPREAD 8'h1c
`define ALHB_IDX_COLD 8'h1d
`define ALHB_IDX_HOT 8'h1e

// ----------------------------------------------------------------------
// Status word bit positions.
// ----------------------------------------------------------------------
`define ALHB_ST_RESET 0
`define ALHB_ST_OVER 1
`define ALHB_ST_UNDER 2
`define ALHB_ST_SPREAD 3
`define ALHB_ST_COLD 4
`define ALHB_ST_HOT 5
`define ALHB_ST_CRC 6
`define ALHB_ST_NACK 7
`define ALHB_ST_FAIL 8
`define ALHB_ST_AUX1 9
`define ALHB_ST_AUX0 10
`define ALHB_ST_WIDTH 11

// Failure word: bit 1 is the heartbeat fault; the rest follow the fail inputs.
`define ALHB_FL_HBEAT 1
`define ALHB_FL_WIDTH 5

// ----------------------------------------------------------------------
// Reset values and thresholds.
// ----------------------------------------------------------------------
`define ALHB_SPREAD_OFF 16'hfff0
`define ALHB_COLD_RST 16'hfff0
`define ALHB_HOT_RST 16'h0000
`define ALHB_ADDR_RST 16'h0000
`define ALHB_RESP_OKAY 2'b00
`define ALHB_RESP_SLVERR 2'b10

// ----------------------------------------------------------------------
// Heartbeat timing.
// ----------------------------------------------------------------------
`define ALHB_CLK_HZ 100000000
`define ALHB_HB_HZ 16384
`define ALHB_HB_HALF_CYC (`ALHB_CLK_HZ / (2 * `ALHB_HB_HZ))
`define ALHB_HB_MIN_CYC (`ALHB_HB_HALF_CYC / 2)
`define ALHB_HB_MAX_CYC (`ALHB_HB_HALF_CYC * 2)

`endif

// ===== design/alhb_pkg.sv
// Purpose: Types shared by the alert, alarm and heartbeat ladder block.
// Assumes: Constants come from alhb_params.svh.
// Notes: Only types; no numbers of the hardware are defined here.
package alhb_pkg;

    // Sixteen-bit reading or threshold word.
    typedef logic [15:0] alhb_word_t;
    // AXI4-Lite data word.
    typedef logic [31:0] alhb_data_t;
    // AXI4-Lite byte address.
    typedef logic [7:0] alhb_addr_t;

endpackage : alhb_pkg

// ===== tb/alhb_alarm_ladder_assertions.sv
// Purpose: Port-level checks for the alarm ladder block.
// Assumes: One clock, synchronous active-low reset.
// Notes: Bound into every instance of the block.
`timescale 1ns/1ps
module alhb_alarm_ladder_chk (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire alhb_pkg::alhb_data_t s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic alarm_lower_port
);
    import alhb_pkg::*;
    // Run of low samples on the lower port; a heartbeat half is never longer.
    logic [12:0] low_run_q;
    always_ff @(posedge aclk) begin
        if (!aresetn || alarm_lower_port) begin
            low_run_q <= 13'h0000;
        end else if (low_run_q != 13'h1fff) begin
            low_run_q <= low_run_q + 13'h0001;
        end
    end
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    chk_reset_alarm_high: assert property ($rose(aresetn) |-> alarm_lower_port)
        else $error("lower port not high after reset");
    chk_hb_low_bound: assert property (low_run_q <= 13'h0beb)
        else $error("lower port low longer than one heartbeat half");
    chk_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |-> ##2 s_axi_bvalid) else $error("write response late");
    chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data late");
    chk_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped before taken");
    chk_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped before taken");
    chk_read_refuse: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read address accepted while data pending");
    chk_write_refuse: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write accepted while response pending");
    chk_ready_back: assert property (s_axi_bvalid && s_axi_bready |=> s_axi_awready && s_axi_wready)
        else $error("write readies not restored");
    cov_write_done: cover property (s_axi_bvalid && s_axi_bready);
    cov_read_done: cover property (s_axi_rvalid && s_axi_rready);
    cov_alarm_rise: cover property ($rose(alarm_lower_port));
endmodule : alhb_alarm_ladder_chk

bind alhb_alarm_ladder alhb_alarm_ladder_chk u_chk (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .alarm_lower_port);

// ===== tb/alhb_alarm_ladder_tb_top.sv
// Purpose: Self-checking bench for the alarm ladder block.
// Assumes: 100 MHz aclk, synchronous active-low reset, AXI4-Lite master tasks.
// Notes: Table rows first, then failure, unmapped, reset and chain-position tests.
`timescale 1ns/1ps
module alhb_alarm_ladder_tb_top;
    import alhb_pkg::*;
    // Row: over/under bits, highest reading, aux readings, {nack,crc}, enables, status, alarm.
    typedef struct {
        logic [11:0] ov;
        logic [11:0] uv;
        alhb_word_t hi;
        alhb_word_t a0;
        alhb_word_t a1;
        logic [1:0] ev;
        logic [6:0] cfg;
        logic [10:0] st;
        logic alarm;
    } alhb_row_s;
    alhb_row_s rows [10] = '{
        '{12'h800, 12'h000, 16'h0250, 16'h4000, 16'h4000, 2'h0, 7'h7f, 11'h002, 1'b1},
        '{12'h800, 12'h000, 16'h0250, 16'h4000, 16'h4000, 2'h0, 7'h7e, 11'h002, 1'b0},
        '{12'h000, 12'h001, 16'h0250, 16'h4000, 16'h4000, 2'h0, 7'h02, 11'h004, 1'b1},
        '{12'h000, 12'h000, 16'h0300, 16'h4000, 16'h4000, 2'h0, 7'h04, 11'h000, 1'b0},
        '{12'h000, 12'h000, 16'h0301, 16'h4000, 16'h4000, 2'h0, 7'h04, 11'h008, 1'b1},
        '{12'h000, 12'h000, 16'h0250, 16'h4000, 16'h8001, 2'h0, 7'h08, 11'h210, 1'b1},
        '{12'h000, 12'h000, 16'h0250, 16'h0fff, 16'h4000, 2'h0, 7'h10, 11'h420, 1'b1},
        '{12'h000, 12'h000, 16'h0250, 16'h4000, 16'h4000, 2'h1, 7'h20, 11'h040, 1'b1},
        '{12'h000, 12'h000, 16'h0250, 16'h4000, 16'h4000, 2'h2, 7'h40, 11'h080, 1'b1},
        '{12'h000, 12'h000, 16'h0250, 16'h4000, 16'h8000, 2'h0, 7'h08, 11'h000, 1'b0}
    };
    alhb_addr_t ra [7] = '{8'h00, 8'h04, 8'h20, 8'h40, 8'h70, 8'h74, 8'h78};
    alhb_data_t rv [7] = '{32'h1, 32'h0, 32'h0, 32'h0, 32'hfff0, 32'hfff0, 32'h0};
    logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0, sdone = 1'b0, crc = 1'b0, nack = 1'b0, pump = 1'b0;
    logic upper = 1'b0, up_run = 1'b0;
    alhb_addr_t awaddr = 8'h00, araddr = 8'h00;
    alhb_data_t wdata = 32'h0, d;
    logic [11:0] ov = 12'h000, uv = 12'h000, up_cnt = 12'h000;
    alhb_word_t hi = 16'h0250, a0 = 16'h4000, a1 = 16'h4000;
    logic awready, wready, bvalid, arready, rvalid, lower, stuck;
    logic [1:0] bresp, rresp, r;
    alhb_data_t rdata;
    logic [15:0] last_gap;
    int n_mismatch = 0, n_checks = 0;

    always #5 aclk = ~aclk;
    // Device above: a 3051-cycle half period, or held high when stopped.
    always @(posedge aclk) begin
        up_cnt <= (up_cnt == 12'hbea) ? 12'h000 : up_cnt + 12'h001;
        if (!up_run) upper <= 1'b1;
        else if (up_cnt == 12'hbea) upper <= ~upper;
    end

    alhb_alarm_ladder #(.CELLS(12)) dut (.aclk, .aresetn, .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .per_cell_over_bits(ov),
        .per_cell_under_bits(uv), .highest_cell_reading(hi), .lowest_cell_reading(16'h0200),
        .aux_input_zero(a0), .aux_input_one(a1), .aux_sample_done(sdone), .crc_error_event(crc),
        .nack_error_event(nack), .pump_fail_event(pump), .reference_fail_event(pump),
        .low_supply_fail_event(1'b0), .low_ground_fail_event(1'b0), .alarm_upper_port(upper),
        .alarm_lower_port(lower));
    alhb_host_monitor mon (.aclk, .aresetn, .line(lower), .stuck, .last_gap);

    // ------------------------------------------------------------------
    // Bus and comparison tasks.
    // ------------------------------------------------------------------
    task automatic check(input string what, input alhb_data_t seen, input alhb_data_t exp);
        n_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic tick(input int n);
        repeat (n) @(posedge aclk);
    endtask : tick
    // Ready is raised only after valid is seen, so the slave must hold its answer.
    task automatic wr(input alhb_addr_t a, input alhb_data_t v, output logic [1:0] q);
        logic done = 1'b0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        while (!done) begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            done = bvalid && bready;
            if (done) q = bresp;
            bready <= bvalid && !bready;
        end
    endtask : wr
    task automatic rd(input alhb_addr_t a, output alhb_data_t v, output logic [1:0] q);
        logic done = 1'b0;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        while (!done) begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
            done = rvalid && rready;
            if (done) v = rdata;
            if (done) q = rresp;
            rready <= rvalid && !rready;
        end
    endtask : rd
    task automatic rchk(input string what, input alhb_addr_t a, input alhb_data_t m, input alhb_data_t e);
        alhb_data_t v;
        logic [1:0] q;
        rd(a, v, q);
        check(what, v & m, e);
    endtask : rchk
    task automatic close_out();
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : close_out

    // ------------------------------------------------------------------
    // Test sequence.
    // ------------------------------------------------------------------
    initial begin
        tick(5);
        aresetn <= 1'b1;
        wr(8'h00, 32'hffff_fffe, r);
        wr(8'h70, 32'h0000_0100, r);
        wr(8'h74, 32'h0000_8000, r);
        wr(8'h78, 32'h0000_1000, r);
        // Each row: clear sticky flags, apply readings, read status, enable, watch the line.
        foreach (rows[i]) begin
            wr(8'h00, 32'h0, r);
            ov <= rows[i].ov;
            uv <= rows[i].uv;
            hi <= rows[i].hi;
            a0 <= rows[i].a0;
            a1 <= rows[i].a1;
            {nack, crc} <= rows[i].ev;
            sdone <= 1'b1;
            @(posedge aclk);
            {nack, crc} <= 2'b00;
            sdone <= 1'b0;
            tick(4);
            rchk("status", 8'h00, 32'h7ff, {21'h0, rows[i].st});
            wr(8'h20, {25'h0, rows[i].cfg}, r);
            tick(3300);
            check("alarm", {31'h0, stuck}, {31'h0, rows[i].alarm});
        end
        // Failure summary: a written one keeps the latched bit, a zero clears it.
        pump <= 1'b1;
        @(posedge aclk);
        pump <= 1'b0;
        tick(4);
        rchk("fail_summary", 8'h00, 32'h100, 32'h100);
        wr(8'h40, 32'hffff_ffff, r);
        rchk("failure_word", 8'h40, 32'h1f, 32'h5);
        wr(8'h40, 32'h0, r);
        rchk("fail_summary", 8'h00, 32'h100, 32'h0);
        rd(8'h0c, d, r);
        check("unmapped_rresp", {30'h0, r}, 32'h2);
        check("unmapped_rdata", d, 32'h0);
        wr(8'h0c, 32'h0, r);
        check("unmapped_bresp", {30'h0, r}, 32'h2);
        // Second reset in mid-run: reset values, alarm until the flag is cleared.
        aresetn <= 1'b0;
        tick(5);
        aresetn <= 1'b1;
        foreach (ra[i]) rchk("reset_value", ra[i], 32'hffff_ffff, rv[i]);
        tick(3300);
        check("reset_alarm", {31'h0, stuck}, 32'h1);
        wr(8'h00, 32'hffff_fffe, r);
        tick(6300);
        check("hb_gap", {16'h0, last_gap}, 32'h0beb);
        // Not the top any more: the upper heartbeat passes through, then stops.
        wr(8'h04, 32'h0000_0201, r);
        up_run <= 1'b1;
        tick(6300);
        wr(8'h40, 32'h0, r);
        tick(3300);
        check("hb_gap_pass", {16'h0, last_gap}, 32'h0beb);
        rchk("hb_fault_clear", 8'h40, 32'h2, 32'h0);
        up_run <= 1'b0;
        tick(6400);
        rchk("hb_fault_set", 8'h40, 32'h2, 32'h2);
        check("pass_high", {31'h0, stuck}, 32'h1);
        close_out();
    end

    // Watchdog: the sequence needs about 60000 cycles.
    initial begin
        tick(90000);
        n_mismatch++;
        close_out();
    end
endmodule : alhb_alarm_ladder_tb_top

// ===== tb/alhb_host_monitor.sv
// Purpose: Host-side watcher of the bottom alarm ladder line.
// Assumes: Line sampled on aclk.
// Notes: Flags a line stuck high and keeps the last gap between line edges.
`timescale 1ns/1ps
module alhb_host_monitor #(
    parameter int STUCK_CYC = 3200
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic line,
    output logic stuck,
    output logic [15:0] last_gap
);
    logic line_q;
    logic [15:0] high_run_q;
    logic [15:0] gap_q;
    // High past any heartbeat half means the heartbeat is lost: an alarm.
    assign stuck = (high_run_q >= 16'(STUCK_CYC));
    // Edge spacing and high run, both counted in clock cycles.
    always_ff @(posedge aclk) begin
        line_q <= line;
        if (!aresetn) begin
            high_run_q <= 16'h0000;
            gap_q <= 16'h0000;
            last_gap <= 16'h0000;
        end else begin
            high_run_q <= line ? high_run_q + 16'h0001 : 16'h0000;
            gap_q <= (line != line_q) ? 16'h0001 : gap_q + 16'h0001;
            if (line != line_q) begin
                last_gap <= gap_q;
            end
        end
    end
endmodule : alhb_host_monitor
